// [dsgsr_params.svh]
`ifndef DSGSR_PARAMS_SVH
`define DSGSR_PARAMS_SVH

`define DSGSR_OFF_SRC0     12'h040
`define DSGSR_OFF_RCFG     12'h060
`define DSGSR_OFF_RCG2     12'h108
`define DSGSR_OFF_SCG2     12'h118
`define DSGSR_OFF_DCG2     12'h128

`define DSGSR_GATE_MASK    32'h0001201f
`define DSGSR_SRC0_MASK    32'h01010048
`define DSGSR_RCFG_MASK    32'h08000000

`define DSGSR_BIT_BUSCTL   16
`define DSGSR_BIT_DMA      13
`define DSGSR_BIT_PORT_E   4
`define DSGSR_BIT_PORT_A   0
`define DSGSR_BIT_CAN      24
`define DSGSR_BIT_CONV     16
`define DSGSR_BIT_HIBERNATE 6
`define DSGSR_BIT_WDOG     3
`define DSGSR_BIT_AUTO_GATE 27

`define DSGSR_RST_GATE     32'h00000000
`define DSGSR_RST_SRC0     32'h00000000
`define DSGSR_RST_RCFG     32'h00000000

`define DSGSR_HTRANS_NSEQ  2'h2

`endif

// [dsgsr_pkg.sv]
package dsgsr_pkg;

  typedef enum logic [1:0] {
    DSGSR_MODE_RUN   = 2'h0,
    DSGSR_MODE_SLEEP = 2'h1,
    DSGSR_MODE_DEEP  = 2'h2
  } dsgsr_mode_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } dsgsr_aphase_t;

  typedef struct packed {
    logic [31:0] clk_en;
    logic [31:0] soft_rst;
  } dsgsr_ctrl_t;

endpackage : dsgsr_pkg

// [dsgsr_top.sv]
`timescale 1ns/1ps
`include "dsgsr_params.svh"

// Operation
// [R1] Run, sleep, deep-sleep registers each gate units
// [R2] Gate bit one clocks unit, zero stops it
// [R3] Access to gated-off unit gives bus fault
// [R4] Deep-sleep gate register resets to zero
// [R5] Bus controller 16, DMA 13, ports 4..0
// [R6] Reserved bits read zero; software preserves them
// [R7] Sleep gating only with auto gating set
// [R8] Reset writes masked by capability bits
// [R9] CAN reset bit 24, converter bit 16
// [R10] Hibernate reset bit 6, watchdog bit 3
// [R11] Soft reset register resets to zero
// [R12] Reset bit one holds unit in reset
module dsgsr_top (
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic [31:0]      HRDATA_O,
  input  wire logic        SLEEP_I,
  input  wire logic        DEEP_SLEEP_I,
  input  wire logic [31:0] CAP_MASK_I,
  input  wire logic [31:0] UNIT_REQ_I,
  output logic [31:0]      UNIT_CLK_EN_O,
  output logic [31:0]      SOFT_RST_O,
  output logic             BUS_FAULT_O
);

  dsgsr_pkg::dsgsr_aphase_t aph_d;
  dsgsr_pkg::dsgsr_aphase_t aph_q;
  dsgsr_pkg::dsgsr_mode_t   mode;
  dsgsr_pkg::dsgsr_ctrl_t   ctrl;

  logic [31:0] rcg_q;
  logic [31:0] rcg_d;
  logic [31:0] scg_q;
  logic [31:0] scg_d;
  logic [31:0] dcg_q;
  logic [31:0] dcg_d;
  logic [31:0] src_q;
  logic [31:0] src_d;
  logic [31:0] rcfg_q;
  logic [31:0] rcfg_d;
  logic [31:0] gate_q;
  logic [31:0] gate_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        fault_q;
  logic        fault_d;

  wire         auto_gate;
  wire         take;
  wire         dph_wr;
  wire         hit_rcg;
  wire         hit_scg;
  wire         hit_dcg;
  wire         hit_src;
  wire         hit_rcfg;
  wire         rd_rcg;
  wire         rd_scg;
  wire         rd_dcg;
  wire         rd_src;
  wire         rd_rcfg;
  wire [31:0]  wr_gate;
  wire [31:0]  wr_src;
  wire [31:0]  wr_rcfg;

  // Address phase is taken only when the previous transfer has finished.
  assign take = HSEL_I && HREADY_I && (HTRANS_I == `DSGSR_HTRANS_NSEQ);
  assign aph_d = '{valid: take,
                   write: HWRITE_I,
                   addr:  HADDR_I[11:0]};

  // Zero wait states; every answer is OKAY, unmapped words read zero.
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = rdata_q;

  assign dph_wr   = aph_q.valid && aph_q.write;
  assign hit_rcg  = aph_q.addr == `DSGSR_OFF_RCG2;
  assign hit_scg  = aph_q.addr == `DSGSR_OFF_SCG2;
  assign hit_dcg  = aph_q.addr == `DSGSR_OFF_DCG2;
  assign hit_src  = aph_q.addr == `DSGSR_OFF_SRC0;
  assign hit_rcfg = aph_q.addr == `DSGSR_OFF_RCFG;

  // Reserved bits are never stored, so they always read back as zero.
  assign wr_gate = HWDATA_I & `DSGSR_GATE_MASK; // [R6] [R5]
  assign wr_src  = HWDATA_I & `DSGSR_SRC0_MASK; // [R9] [R10]
  assign wr_rcfg = HWDATA_I & `DSGSR_RCFG_MASK;

  // Absent units keep their current soft reset bit instead of taking the write.
  assign src_d  = (dph_wr && hit_src) ?
                  ((src_q & ~CAP_MASK_I) | (wr_src & CAP_MASK_I)) : src_q; // [R8]
  assign rcg_d  = (dph_wr && hit_rcg) ? wr_gate : rcg_q;
  assign scg_d  = (dph_wr && hit_scg) ? wr_gate : scg_q;
  assign dcg_d  = (dph_wr && hit_dcg) ? wr_gate : dcg_q;
  assign rcfg_d = (dph_wr && hit_rcfg) ? wr_rcfg : rcfg_q;

  assign rd_rcg  = HADDR_I[11:0] == `DSGSR_OFF_RCG2;
  assign rd_scg  = HADDR_I[11:0] == `DSGSR_OFF_SCG2;
  assign rd_dcg  = HADDR_I[11:0] == `DSGSR_OFF_DCG2;
  assign rd_src  = HADDR_I[11:0] == `DSGSR_OFF_SRC0;
  assign rd_rcfg = HADDR_I[11:0] == `DSGSR_OFF_RCFG;

  // Read data is fetched in the address phase so it leaves a flop.
  // A read directly behind a write to the same word would see the old value;
  // the bus here always idles between transfers, so no forwarding is kept.
  assign rdata_d = !(take && !HWRITE_I) ? 32'h00000000 :
                   rd_rcg  ? rcg_q  :
                   rd_scg  ? scg_q  :
                   rd_dcg  ? dcg_q  :
                   rd_src  ? src_q  :
                   rd_rcfg ? rcfg_q : 32'h00000000;

  assign auto_gate = rcfg_q[`DSGSR_BIT_AUTO_GATE];
  assign mode = DEEP_SLEEP_I ? dsgsr_pkg::DSGSR_MODE_DEEP :
                SLEEP_I      ? dsgsr_pkg::DSGSR_MODE_SLEEP :
                               dsgsr_pkg::DSGSR_MODE_RUN;

  // Without auto gating the run register stays in charge in every mode.
  always_comb begin
    unique case (mode)
      dsgsr_pkg::DSGSR_MODE_DEEP:  gate_d = auto_gate ? dcg_q : rcg_q; // [R1] [R7]
      dsgsr_pkg::DSGSR_MODE_SLEEP: gate_d = auto_gate ? scg_q : rcg_q; // [R1] [R7]
      dsgsr_pkg::DSGSR_MODE_RUN:   gate_d = rcg_q; // [R1]
      default:                     gate_d = rcg_q;
    endcase
  end

  // Faults use the registered enables, so a request as a gate opens still faults.
  assign fault_d = |(UNIT_REQ_I & ~gate_q); // [R3]

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      aph_q   <= '0;
      rdata_q <= 32'h00000000;
    end else begin
      aph_q   <= aph_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      rcg_q  <= `DSGSR_RST_GATE;
      scg_q  <= `DSGSR_RST_GATE;
      dcg_q  <= `DSGSR_RST_GATE; // [R4]
      src_q  <= `DSGSR_RST_SRC0; // [R11]
      rcfg_q <= `DSGSR_RST_RCFG;
    end else begin
      rcg_q  <= rcg_d;
      scg_q  <= scg_d;
      dcg_q  <= dcg_d;
      src_q  <= src_d;
      rcfg_q <= rcfg_d;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      gate_q  <= `DSGSR_RST_GATE;
      fault_q <= 1'b0;
    end else begin
      gate_q  <= gate_d; // [R2]
      fault_q <= fault_d;
    end
  end

  assign ctrl = '{clk_en:   gate_q,
                  soft_rst: src_q};
  assign UNIT_CLK_EN_O = ctrl.clk_en; // [R2]
  assign SOFT_RST_O    = ctrl.soft_rst; // [R12]
  assign BUS_FAULT_O   = fault_q;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence s_wr_dcg;
    dph_wr && hit_dcg;
  endsequence

  sequence s_wr_src;
    dph_wr && hit_src;
  endsequence

  sequence s_deep_auto;
    DEEP_SLEEP_I && auto_gate;
  endsequence

  sequence s_rd_dcg;
    take && !HWRITE_I && rd_dcg;
  endsequence

  sequence s_rd_src;
    take && !HWRITE_I && rd_src;
  endsequence

  sequence s_rd_none;
    take && !HWRITE_I && !(rd_rcg || rd_scg || rd_dcg || rd_src || rd_rcfg);
  endsequence

  sequence s_gated_req;
    |(UNIT_REQ_I & ~UNIT_CLK_EN_O);
  endsequence

  sequence s_open_req;
    !(|(UNIT_REQ_I & ~UNIT_CLK_EN_O));
  endsequence

  AST_DCG_RESET_ZERO: assert property ( // [R4]
    disable iff (1'b0) RESET_I |-> (dcg_q == 32'h00000000))
    else $error("Deep-sleep gate register not zero in reset.");

  AST_SRC_RESET_ZERO: assert property ( // [R11]
    disable iff (1'b0) RESET_I |-> (SOFT_RST_O == 32'h00000000))
    else $error("Soft reset outputs not zero in reset.");

  AST_DCG_FIELDS: assert property ( // [R5]
    s_wr_dcg |=> (dcg_q == ($past(HWDATA_I) & 32'h0001201f)))
    else $error("Deep-sleep gate write stored wrong bits.");

  AST_RESERVED_ZERO: assert property ( // [R6]
    ((dcg_q & ~32'h0001201f) == 32'h0) && ((src_q & ~32'h01010048) == 32'h0))
    else $error("Reserved bit holds a one.");

  AST_RESERVED_READ: assert property ( // [R6]
    take && !HWRITE_I && rd_dcg |=> ((HRDATA_O & 32'hfffedfe0) == 32'h0))
    else $error("Reserved bits read back as one.");

  AST_DEEP_GATING: assert property ( // [R1]
    s_deep_auto |=> (UNIT_CLK_EN_O == $past(dcg_q)))
    else $error("Deep-sleep did not apply its gate register.");

  AST_NO_AUTO_RUN: assert property ( // [R7]
    !auto_gate |=> (UNIT_CLK_EN_O == $past(rcg_q)))
    else $error("Gating changed without auto gating.");

  AST_SLEEP_GATING: assert property ( // [R1]
    SLEEP_I && !DEEP_SLEEP_I && auto_gate |=> (UNIT_CLK_EN_O == $past(scg_q)))
    else $error("Sleep did not apply its gate register.");

  AST_FAULT_GATED: assert property ( // [R3]
    (|(UNIT_REQ_I & ~UNIT_CLK_EN_O)) |=> BUS_FAULT_O)
    else $error("Access to gated unit did not fault.");

  AST_FAULT_OPEN: assert property ( // [R2]
    !(|(UNIT_REQ_I & ~UNIT_CLK_EN_O)) |=> !BUS_FAULT_O)
    else $error("Fault raised for a clocked unit.");

  AST_CAP_MASK: assert property ( // [R8]
    s_wr_src |=> ((SOFT_RST_O & ~$past(CAP_MASK_I)) == ($past(src_q) & ~$past(CAP_MASK_I))))
    else $error("Write reached an absent unit reset bit.");

  AST_CAN_RESET: assert property ( // [R9]
    s_wr_src ##0 (HWDATA_I[24] && CAP_MASK_I[24]) |=> SOFT_RST_O[24])
    else $error("CAN reset bit not set.");

  AST_HIBERNATE_RESET: assert property ( // [R10]
    s_wr_src ##0 (HWDATA_I[6] && CAP_MASK_I[6]) |=> SOFT_RST_O[6])
    else $error("Hibernate reset bit not set.");

  AST_WDOG_RELEASE: assert property ( // [R12]
    s_wr_src ##0 (!HWDATA_I[3] && CAP_MASK_I[3]) ##1 !(dph_wr && hit_src)
      |-> !SOFT_RST_O[3] [*2])
    else $error("Watchdog not released from reset.");

  AST_OKAY_ZERO_WAIT: assert property (
    HREADYOUT_O && !HRESP_O)
    else $error("Slave inserted wait or error.");

  AST_BUSCTL_GATE: assert property ( // [R5]
    s_wr_dcg |=> (dcg_q[`DSGSR_BIT_BUSCTL] == $past(HWDATA_I[`DSGSR_BIT_BUSCTL])))
    else $error("Bus controller gate bit not stored.");

  AST_DMA_GATE: assert property ( // [R5]
    s_wr_dcg |=> (dcg_q[`DSGSR_BIT_DMA] == $past(HWDATA_I[`DSGSR_BIT_DMA])))
    else $error("DMA gate bit not stored.");

  AST_PORT_GATES: assert property ( // [R5]
    s_wr_dcg |=> (dcg_q[`DSGSR_BIT_PORT_E:`DSGSR_BIT_PORT_A] ==
                  $past(HWDATA_I[`DSGSR_BIT_PORT_E:`DSGSR_BIT_PORT_A])))
    else $error("Port gate bits not stored.");

  AST_DCG_HOLD: assert property ( // [R5]
    !(dph_wr && hit_dcg) |=> $stable(dcg_q))
    else $error("Deep-sleep gate register changed without a write.");

  AST_CONV_RESET: assert property ( // [R9]
    s_wr_src ##0 (HWDATA_I[`DSGSR_BIT_CONV] && CAP_MASK_I[`DSGSR_BIT_CONV])
      |=> SOFT_RST_O[`DSGSR_BIT_CONV])
    else $error("Converter reset bit not set.");

  AST_WDOG_RESET: assert property ( // [R10]
    s_wr_src ##0 (HWDATA_I[`DSGSR_BIT_WDOG] && CAP_MASK_I[`DSGSR_BIT_WDOG])
      |=> SOFT_RST_O[`DSGSR_BIT_WDOG])
    else $error("Watchdog reset bit not set.");

  AST_CAN_RELEASE: assert property ( // [R12]
    s_wr_src ##0 (!HWDATA_I[`DSGSR_BIT_CAN] && CAP_MASK_I[`DSGSR_BIT_CAN])
      |=> !SOFT_RST_O[`DSGSR_BIT_CAN])
    else $error("CAN unit not released from reset.");

  AST_HIBERNATE_RELEASE: assert property ( // [R12]
    s_wr_src ##0 (!HWDATA_I[`DSGSR_BIT_HIBERNATE] && CAP_MASK_I[`DSGSR_BIT_HIBERNATE])
      |=> !SOFT_RST_O[`DSGSR_BIT_HIBERNATE])
    else $error("Hibernate unit not released from reset.");

  AST_SRC_HOLD: assert property ( // [R12]
    !(dph_wr && hit_src) |=> $stable(SOFT_RST_O))
    else $error("Soft reset outputs changed without a write.");

  AST_RUN_GATING: assert property ( // [R1]
    !SLEEP_I && !DEEP_SLEEP_I |=> (UNIT_CLK_EN_O == $past(rcg_q)))
    else $error("Run mode did not apply its gate register.");

  AST_READ_DCG: assert property ( // [R5]
    s_rd_dcg |=> (HRDATA_O == $past(dcg_q)))
    else $error("Deep-sleep gate read returned wrong data.");

  AST_READ_SRC: assert property ( // [R9]
    s_rd_src |=> (HRDATA_O == $past(src_q)))
    else $error("Soft reset read returned wrong data.");

  AST_UNMAPPED_READ: assert property ( // [R6]
    s_rd_none |=> (HRDATA_O == 32'h00000000))
    else $error("Unmapped word did not read zero.");

  AST_SRC_RESERVED_READ: assert property ( // [R6]
    s_rd_src |=> ((HRDATA_O & ~`DSGSR_SRC0_MASK) == 32'h00000000))
    else $error("Soft reset reserved bits read back as one.");

  AST_RCFG_RESERVED: assert property ( // [R7]
    (rcfg_q & ~`DSGSR_RCFG_MASK) == 32'h00000000)
    else $error("Clock config holds a bit other than auto gating.");

  AST_READ_IDLE: assert property (
    !(take && !HWRITE_I) |=> (HRDATA_O == 32'h00000000))
    else $error("Read data stood without a read.");

  AST_FAULT_RISE: assert property ( // [R3]
    s_open_req ##1 s_gated_req |=> $rose(BUS_FAULT_O))
    else $error("Fault did not rise for a new gated request.");

  AST_FAULT_FALL: assert property ( // [R2]
    s_gated_req ##1 s_open_req |=> $fell(BUS_FAULT_O))
    else $error("Fault did not fall once the request was clocked.");

endmodule : dsgsr_top

// [testbench.sv]
`timescale 1ns/1ps
`include "dsgsr_params.svh"
module testbench;
  logic        clk    = 1'b0;
  logic        rst    = 1'b0;
  logic [2:0]  hsize  = 3'h0;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        sleep  = 1'b0;
  logic        deep   = 1'b0;
  logic [31:0] cap    = 32'h0;
  logic [31:0] req    = 32'h0;
  logic [31:0] rd;
  wire logic        hready;
  wire logic        hresp;
  wire logic        fault;
  wire logic [31:0] hrdata;
  wire logic [31:0] clk_en;
  wire logic [31:0] soft_rst;
  int checks = 0;
  int fail_count = 0;

  always #20 clk = ~clk;

  // Single slave, so its ready output is the bus ready.
  dsgsr_top dsgsr_top_i (
    .REF_CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata),
    .SLEEP_I(sleep), .DEEP_SLEEP_I(deep), .CAP_MASK_I(cap), .UNIT_REQ_I(req),
    .UNIT_CLK_EN_O(clk_en), .SOFT_RST_O(soft_rst), .BUS_FAULT_O(fault));

  task results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Read data is taken in the active region of the data-phase end edge,
  // before the slave's own updates of that edge land.
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= `DSGSR_HTRANS_NSEQ;
    haddr  <= {20'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus

  task rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask : rdchk

  task settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task t_reset();
    rdchk("dcg2 reset", `DSGSR_OFF_DCG2, 32'h0);
    rdchk("src0 reset", `DSGSR_OFF_SRC0, 32'h0);
    chk("clk_en reset", clk_en, 32'h0);
    chk("soft_rst reset", soft_rst, 32'h0);
  endtask : t_reset

  task t_gate();
    bus(1'b1, `DSGSR_OFF_DCG2, 32'hffffffff);
    rdchk("dcg2 fields", `DSGSR_OFF_DCG2, 32'h0001201f);
    bus(1'b1, `DSGSR_OFF_RCG2, 32'h00000001);
    bus(1'b1, `DSGSR_OFF_RCFG, 32'h1 << `DSGSR_BIT_AUTO_GATE);
    deep <= 1'b1;
    settle();
    chk("deep gating", clk_en, 32'h0001201f);
    deep  <= 1'b0;
    sleep <= 1'b1;
    settle();
    chk("sleep gating", clk_en, 32'h0);
    bus(1'b1, `DSGSR_OFF_RCFG, 32'h0);
    sleep <= 1'b0;
    deep  <= 1'b1;
    settle();
    chk("deep without auto", clk_en, 32'h00000001);
  endtask : t_gate

  task fault_at(input logic [31:0] r, input logic exp);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    #1;
    chk("bus fault", {31'h0, fault}, {31'h0, exp});
  endtask : fault_at

  // Only port A is clocked here, so the DMA request must fault.
  task t_fault();
    fault_at(32'h00000001, 1'b0);
    fault_at(32'h00002000, 1'b1);
    fault_at(32'h0, 1'b0);
  endtask : t_fault

  task t_srst();
    @(posedge clk);
    cap <= 32'h01000008;
    bus(1'b1, `DSGSR_OFF_SRC0, 32'hffffffff);
    rdchk("src0 masked", `DSGSR_OFF_SRC0, 32'h01000008);
    @(posedge clk);
    cap <= 32'hffffffff;
    bus(1'b1, `DSGSR_OFF_SRC0, 32'hffffffff);
    #1;
    chk("soft_rst held", soft_rst, 32'h01010048);
    rdchk("src0 fields", `DSGSR_OFF_SRC0, 32'h01010048);
    @(posedge clk);
    cap <= 32'h0;
    bus(1'b1, `DSGSR_OFF_SRC0, 32'h0);
    rdchk("src0 no cap", `DSGSR_OFF_SRC0, 32'h01010048);
    @(posedge clk);
    cap <= 32'hffffffff;
    bus(1'b1, `DSGSR_OFF_SRC0, 32'h0);
    #1;
    chk("soft_rst released", soft_rst, 32'h0);
    bus(1'b1, 12'h0fc, 32'hffffffff);
    rdchk("unmapped", 12'h0fc, 32'h0);
  endtask : t_srst

  // Reset rises by a deferred update at time zero, so the asynchronous
  // reset branch sees an edge and the state is known before the first clock.
  initial begin
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_gate();
    t_fault();
    t_srst();
    results();
  end

  // The whole sequence needs under a hundred cycles; this is ample.
  initial begin
    #200000;
    fail_count++;
    results();
  end
endmodule : testbench
